/* sipm_pkg.sv */
package sipm_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned REG_WAKE_DELAY_NS = 190000;
  // Least time, rounded up to whole cycles
  localparam int unsigned REG_WAKE_CYCLES =
    (REG_WAKE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned OSC_START_CYCLES = 16;

  // ****************************************
  // Operands and fields
  // ****************************************
  localparam logic [7:0] OPERAND_SLEEP = 8'h00;
  localparam logic [7:0] OPERAND_IDLE = 8'h01;
  localparam int unsigned REGULATOR_SLEEP_KEEP_BIT = 8;
  localparam int unsigned OSC_SEL_W = 3;
  localparam logic [OSC_SEL_W-1:0] OSC_SEL_RESET = 3'h0;
  localparam logic [OSC_SEL_W-1:0] OSC_SEL_INTERNAL_FAST = 3'h0;

  typedef enum {
    SIPM_RUN,
    SIPM_IDLE,
    SIPM_SLEEP,
    SIPM_OSC_START,
    SIPM_REG_WAKE
  } sipm_state_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic sys_osc_en;
    logic int_osc_en;
    logic fail_safe_en;
    logic low_power_rc_clock_en;
    logic regulator_standby;
  } sipm_ctrl_t;

  typedef struct packed {
    logic irq;
    logic wdt_timeout;
  } sipm_wake_t;

endpackage : sipm_pkg

/* sipm_power_manager.sv */
// Functional notes
// - Sleep or idle entered only by power-save instruction with matching operand.
// - Sleep stops clocks and suspends all program execution.
// - Idle stops CPU and execution, peripherals keep running.
// - Enabled interrupt, watchdog time-out or any reset ends either state.
// - Sleep shuts system clock source, internal oscillator off when in use.
// - Fail-safe clock monitor inactive throughout sleep.
// - Low-power RC clock runs in sleep while watchdog enabled.
// - Watchdog counter clear pulsed in the first sleep cycle when watchdog enabled.
// - System-clock peripherals disabled in sleep; change detect, external clocks stay.
// - Regulator standby in sleep when regulator-sleep keep bit clear.
// - Regulator standby adds about 190 us to sleep wake-up.
// - Sleep wake resumes on the clock source selected at entry.
// - Unlocked clock configuration lets new oscillator select switch source.
module sipm_power_manager #(
  parameter int unsigned REG_WAKE_CYCLES_P = sipm_pkg::REG_WAKE_CYCLES,
  parameter int unsigned OSC_START_CYCLES_P = sipm_pkg::OSC_START_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic power_save_exec_i,
  input wire logic [7:0] power_save_operand_i,
  input wire sipm_pkg::sipm_wake_t wake_i,
  input wire logic wdt_enable_i,
  input wire logic [15:0] reset_control_register_i,
  input wire logic clk_cfg_lock_i,
  input wire logic osc_select_wr_i,
  input wire logic [sipm_pkg::OSC_SEL_W-1:0] new_oscillator_select_i,
  output sipm_pkg::sipm_ctrl_t ctrl_o,
  output logic [sipm_pkg::OSC_SEL_W-1:0] osc_source_o,
  output logic wdt_clear_o,
  output logic cpu_halted_o,
  output sipm_pkg::sipm_state_t state_o
);
  import sipm_pkg::*;

  // ****************************************
  // Wake sources
  // ****************************************
  // Inputs come from on-chip logic on clk_i, so no synchroniser
  logic wake_any;
  assign wake_any = wake_i.irq | wake_i.wdt_timeout;

  logic cmd_sleep;
  logic cmd_idle;
  assign cmd_sleep = power_save_exec_i && (power_save_operand_i == OPERAND_SLEEP);
  assign cmd_idle = power_save_exec_i && (power_save_operand_i == OPERAND_IDLE);

  // ****************************************
  // State machine
  // ****************************************
  sipm_state_t state_reg;
  sipm_state_t state_next;
  logic [31:0] cnt_reg;
  logic reg_standby_reg;
  logic [OSC_SEL_W-1:0] osc_reg;

  logic regulator_keep;
  assign regulator_keep = reset_control_register_i[REGULATOR_SLEEP_KEEP_BIT];

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SIPM_RUN: begin
        if (cmd_sleep) begin
          state_next = SIPM_SLEEP;
        end else if (cmd_idle) begin
          state_next = SIPM_IDLE;
        end
      end
      SIPM_IDLE: begin
        if (wake_any) begin
          state_next = SIPM_RUN;
        end
      end
      SIPM_SLEEP: begin
        if (wake_any) begin
          state_next = SIPM_OSC_START;
        end
      end
      SIPM_OSC_START: begin
        if (cnt_reg == 32'(OSC_START_CYCLES_P - 1)) begin
          state_next = reg_standby_reg ? SIPM_REG_WAKE : SIPM_RUN;
        end
      end
      SIPM_REG_WAKE: begin
        if (cnt_reg == 32'(REG_WAKE_CYCLES_P - 1)) begin
          state_next = SIPM_RUN;
        end
      end
    endcase
  end

  // Any reset returns to run through the asynchronous clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SIPM_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else if (state_next != state_reg) begin
      cnt_reg <= '0;
    end else if (state_reg == SIPM_OSC_START || state_reg == SIPM_REG_WAKE) begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end

  // Standby decision latched at entry; later writes cannot skew the wake delay
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_standby_reg <= 1'b0;
    end else if (state_reg == SIPM_RUN && cmd_sleep) begin
      reg_standby_reg <= !regulator_keep;
    end
  end

  // ****************************************
  // Clock source selection
  // ****************************************
  // Only changes in run, so sleep wake keeps the entry source
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_reg <= OSC_SEL_RESET;
    end else if (state_reg == SIPM_RUN && osc_select_wr_i && !clk_cfg_lock_i) begin
      osc_reg <= new_oscillator_select_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdt_clear_o <= 1'b0;
    end else begin
      wdt_clear_o <= state_reg == SIPM_RUN && cmd_sleep && wdt_enable_i;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic in_sleep;
  assign in_sleep = state_reg == SIPM_SLEEP;

  always_comb begin
    ctrl_o.cpu_clk_en = state_reg == SIPM_RUN;
    ctrl_o.periph_clk_en = state_reg == SIPM_RUN || state_reg == SIPM_IDLE;
    ctrl_o.sys_osc_en = !in_sleep;
    ctrl_o.int_osc_en = !(in_sleep && osc_reg == OSC_SEL_INTERNAL_FAST);
    ctrl_o.fail_safe_en = state_reg == SIPM_RUN || state_reg == SIPM_IDLE;
    ctrl_o.low_power_rc_clock_en = !in_sleep || wdt_enable_i;
    ctrl_o.regulator_standby = in_sleep && reg_standby_reg;
  end

  assign osc_source_o = osc_reg;
  assign cpu_halted_o = state_reg != SIPM_RUN;
  assign state_o = state_reg;

  // ****************************************
  // Checks
  // ****************************************
  // Own count of wake cycles, so the checks do not lean on the sequencing counter
  logic [31:0] wake_len_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_len_reg <= '0;
    end else if (state_reg == SIPM_OSC_START || state_reg == SIPM_REG_WAKE) begin
      wake_len_reg <= wake_len_reg + 32'h1;
    end else begin
      wake_len_reg <= '0;
    end
  end

  sequence s_sleep_cmd;
    state_reg == SIPM_RUN && cmd_sleep;
  endsequence

  sequence s_wake_start;
    state_reg == SIPM_SLEEP && wake_any;
  endsequence

  chk_sleep_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_sleep_cmd |=> state_reg == SIPM_SLEEP)
    else $error("sleep not entered");

  chk_idle_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_RUN && cmd_idle && !cmd_sleep |=> state_reg == SIPM_IDLE
      && ctrl_o.periph_clk_en && !ctrl_o.cpu_clk_en)
    else $error("idle entry wrong");

  chk_sleep_clocks: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_SLEEP |-> !ctrl_o.cpu_clk_en && !ctrl_o.periph_clk_en
      && !ctrl_o.sys_osc_en && !ctrl_o.fail_safe_en)
    else $error("clock alive in sleep");

  chk_rc_watchdog: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wdt_enable_i |-> ctrl_o.low_power_rc_clock_en)
    else $error("rc clock off with watchdog");

  chk_wdt_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_sleep_cmd ##0 wdt_enable_i |=> wdt_clear_o && state_reg == SIPM_SLEEP)
    else $error("watchdog not cleared");

  chk_idle_wake: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_IDLE && wake_any |=> state_reg == SIPM_RUN && ctrl_o.sys_osc_en)
    else $error("idle wake wrong");

  chk_fast_wake: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_wake_start ##0 !reg_standby_reg |-> ##[1:300] state_reg == SIPM_RUN)
    else $error("sleep wake too slow");

  chk_reg_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(state_reg == SIPM_REG_WAKE) |-> state_reg == SIPM_REG_WAKE [*8])
    else $error("regulator delay cut short");

  chk_source_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg != SIPM_RUN |=> osc_reg == $past(osc_reg))
    else $error("source changed while halted");

  chk_lock_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clk_cfg_lock_i |=> osc_reg == $past(osc_reg))
    else $error("locked source changed");

  chk_run_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_RUN && !cmd_sleep && !cmd_idle |=> state_reg == SIPM_RUN)
    else $error("left run without command");

  chk_sleep_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_SLEEP && !wake_any |=> state_reg == SIPM_SLEEP)
    else $error("sleep left without wake");

  chk_idle_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_IDLE && !wake_any |=> state_reg == SIPM_IDLE)
    else $error("idle left without wake");

  chk_idle_clocks: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_IDLE |-> !ctrl_o.cpu_clk_en && ctrl_o.periph_clk_en && cpu_halted_o)
    else $error("idle clocks wrong");

  chk_sleep_wake: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_wake_start |=> state_reg == SIPM_OSC_START)
    else $error("sleep wake not taken");

  chk_osc_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_OSC_START && wake_len_reg != 32'(OSC_START_CYCLES_P - 1)
      |=> state_reg == SIPM_OSC_START)
    else $error("oscillator start cut short");

  chk_fast_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_OSC_START && wake_len_reg == 32'(OSC_START_CYCLES_P - 1)
      && !reg_standby_reg |=> state_reg == SIPM_RUN)
    else $error("fast wake did not end");

  chk_slow_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_OSC_START && wake_len_reg == 32'(OSC_START_CYCLES_P - 1)
      && reg_standby_reg |=> state_reg == SIPM_REG_WAKE)
    else $error("regulator delay skipped");

  chk_reg_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_REG_WAKE
      && wake_len_reg != 32'(OSC_START_CYCLES_P + REG_WAKE_CYCLES_P - 1)
      |=> state_reg == SIPM_REG_WAKE)
    else $error("regulator delay too short");

  chk_reg_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_REG_WAKE
      && wake_len_reg == 32'(OSC_START_CYCLES_P + REG_WAKE_CYCLES_P - 1)
      |=> state_reg == SIPM_RUN)
    else $error("regulator delay too long");

  chk_int_osc_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_SLEEP && osc_reg == OSC_SEL_INTERNAL_FAST |-> !ctrl_o.int_osc_en)
    else $error("internal oscillator on in sleep");

  chk_osc_awake: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg != SIPM_SLEEP |-> ctrl_o.sys_osc_en && ctrl_o.int_osc_en)
    else $error("oscillator off while awake");

  chk_fail_safe_run: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_RUN |-> ctrl_o.fail_safe_en)
    else $error("fail-safe off in run");

  chk_periph_wake: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_OSC_START || state_reg == SIPM_REG_WAKE
      |-> !ctrl_o.periph_clk_en && !ctrl_o.cpu_clk_en)
    else $error("clocks alive before wake ends");

  chk_clear_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wdt_clear_o |=> !wdt_clear_o)
    else $error("watchdog clear too long");

  chk_clear_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_sleep_cmd ##0 !wdt_enable_i |=> !wdt_clear_o)
    else $error("clear with watchdog off");

  chk_reg_standby: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_sleep_cmd ##0 !regulator_keep |=> ctrl_o.regulator_standby)
    else $error("regulator not in standby");

  chk_reg_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_sleep_cmd ##0 regulator_keep |=> !ctrl_o.regulator_standby)
    else $error("regulator standby while kept");

  chk_standby_sleep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg != SIPM_SLEEP |-> !ctrl_o.regulator_standby)
    else $error("standby outside sleep");

  chk_osc_switch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_RUN && osc_select_wr_i && !clk_cfg_lock_i
      |=> osc_reg == $past(new_oscillator_select_i))
    else $error("source write lost");

  chk_idle_osc_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == SIPM_IDLE |-> ctrl_o.sys_osc_en && ctrl_o.int_osc_en)
    else $error("oscillator stopped in idle");

endmodule : sipm_power_manager

/* sipm_power_manager_tb.sv */
module sipm_power_manager_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sipm_pkg::*;

  // ****************************************
  // Harness
  // ****************************************
  `define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
    $display("[ERR] %s exp %h got %h", nm, ex, gt); n_errors++; end end

  localparam int unsigned REG_W = 20;
  localparam int unsigned OSC_W = 4;
  typedef struct {
    logic [7:0] op; logic wdt; logic b8; logic by_wdt;
    sipm_state_t st; logic [6:0] ctl; logic clr; int wk;
  } sipm_row_t;

  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic exec = 1'h0;
  logic [7:0] op = 8'h00;
  sipm_wake_t wake = '0;
  logic wdt_en = 1'h0;
  logic b8 = 1'h1;
  logic lock = 1'h0;
  logic osel_wr = 1'h0;
  logic [OSC_SEL_W-1:0] nsel = 3'h0;
  sipm_ctrl_t ctrl;
  logic [OSC_SEL_W-1:0] osc;
  logic wclr;
  logic halted;
  sipm_state_t state;
  int n_errors = 0;
  int num_checks = 0;
  int n;
  // Sleep wake: 1 take edge, oscillator start, optional regulator delay
  sipm_row_t rows [6] = '{
    '{8'h01, 1'h1, 1'h1, 1'h0, SIPM_IDLE, 7'h3e, 1'h0, 1},
    '{8'h01, 1'h1, 1'h0, 1'h1, SIPM_IDLE, 7'h3e, 1'h0, 1},
    '{8'h00, 1'h1, 1'h1, 1'h0, SIPM_SLEEP, 7'h02, 1'h1, 1 + OSC_W},
    '{8'h00, 1'h0, 1'h0, 1'h0, SIPM_SLEEP, 7'h01, 1'h0, 1 + OSC_W + REG_W},
    '{8'h00, 1'h1, 1'h0, 1'h1, SIPM_SLEEP, 7'h03, 1'h1, 1 + OSC_W + REG_W},
    '{8'h02, 1'h1, 1'h1, 1'h0, SIPM_RUN, 7'h7e, 1'h0, 0}
  };

  sipm_power_manager #(.REG_WAKE_CYCLES_P(REG_W), .OSC_START_CYCLES_P(OSC_W)) u_dut (
    .clk_i(clk), .rst_n_i(rst_n), .power_save_exec_i(exec), .power_save_operand_i(op),
    .wake_i(wake), .wdt_enable_i(wdt_en), .reset_control_register_i({7'h00, b8, 8'h00}),
    .clk_cfg_lock_i(lock), .osc_select_wr_i(osel_wr), .new_oscillator_select_i(nsel),
    .ctrl_o(ctrl), .osc_source_o(osc), .wdt_clear_o(wclr), .cpu_halted_o(halted),
    .state_o(state)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic wrap_up;
    if (n_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic cmd(input logic [7:0] code);
    exec = 1'h1;
    op = code;
    @(negedge clk);
    exec = 1'h0;
  endtask : cmd

  task automatic osc_write(input logic [OSC_SEL_W-1:0] code);
    osel_wr = 1'h1;
    nsel = code;
    @(negedge clk);
    osel_wr = 1'h0;
    @(negedge clk);
  endtask : osc_write

  // Bounded wait so a stuck state machine cannot hang the run
  task automatic do_wake(input logic by_wdt, output int cnt);
    wake.irq = ~by_wdt;
    wake.wdt_timeout = by_wdt;
    cnt = 0;
    do begin
      @(negedge clk);
      wake = '0;
      cnt++;
    end while (state !== SIPM_RUN && cnt < 200);
  endtask : do_wake

  initial begin
    #10000;
    n_errors++;
    wrap_up();
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'h1;
    `CHK("ctrl_rst", 7'h7e, ctrl)
    `CHK("osc_rst", 3'h0, osc)
    foreach (rows[i]) begin
      wdt_en = rows[i].wdt;
      b8 = rows[i].b8;
      cmd(rows[i].op);
      `CHK("state", rows[i].st, state)
      `CHK("ctrl", rows[i].ctl, ctrl)
      `CHK("wdt_clear", rows[i].clr, wclr)
      `CHK("halted", rows[i].st != SIPM_RUN, halted)
      if (rows[i].wk > 0) begin
        do_wake(rows[i].by_wdt, n);
        `CHK("wake_cycles", rows[i].wk, n)
        `CHK("ctrl_run", 7'h7e, ctrl)
      end
    end
    wdt_en = 1'h1;
    b8 = 1'h1;
    osc_write(3'h5);
    `CHK("osc_sel", 3'h5, osc)
    lock = 1'h1;
    osc_write(3'h2);
    `CHK("osc_locked", 3'h5, osc)
    lock = 1'h0;
    // External source in use: internal oscillator stays up in sleep
    cmd(8'h00);
    `CHK("ctrl_ext", 7'h0a, ctrl)
    @(negedge clk);
    cmd(8'h01);
    `CHK("cmd_in_sleep", SIPM_SLEEP, state)
    `CHK("clr_pulse", 1'h0, wclr)
    do_wake(1'h0, n);
    `CHK("wake_ext", 1 + OSC_W, n)
    `CHK("osc_kept", 3'h5, osc)
    // Regulator standby wake, looked at in each phase
    b8 = 1'h0;
    cmd(8'h00);
    wake.irq = 1'h1;
    @(negedge clk);
    wake = '0;
    `CHK("state_osc", SIPM_OSC_START, state)
    `CHK("ctrl_osc", 7'h1a, ctrl)
    `CHK("halted_osc", 1'h1, halted)
    repeat (OSC_W) @(negedge clk);
    `CHK("state_regw", SIPM_REG_WAKE, state)
    `CHK("ctrl_regw", 7'h1a, ctrl)
    do_wake(1'h0, n);
    `CHK("regw_rest", REG_W, n)
    `CHK("osc_kept2", 3'h5, osc)
    cmd(8'h01);
    osc_write(3'h3);
    `CHK("osc_idle", 3'h5, osc)
    rst_n = 1'h0;
    #1;
    `CHK("state_rst", SIPM_RUN, state)
    `CHK("osc_rst2", 3'h0, osc)
    @(negedge clk);
    rst_n = 1'h1;
    `CHK("ctrl_rst2", 7'h7e, ctrl)
    @(negedge clk);
    `CHK("state_rel", SIPM_RUN, state)
    `CHK("wclr_rel", 1'h0, wclr)
    `CHK("halted_rel", 1'h0, halted)
    cmd(8'h00);
    `CHK("state_rel_cmd", SIPM_SLEEP, state)
    `CHK("wclr_rel_cmd", 1'h1, wclr)
    wrap_up();
  end
endmodule : sipm_power_manager_tb
